// ### inc/slu_regs.svh
// Register indices, field positions, reset values and timing counts
`ifndef SLU_REGS_SVH
`define SLU_REGS_SVH
`define SLU_IDX_MODE     10'h110
`define SLU_IDX_INTERP   10'h111
`define SLU_IDX_PWR      10'h200
`define SLU_IDX_LPD      10'h201
`define SLU_IDX_PLLST    10'h281
`define SLU_IDX_DIVNUM   10'h282
`define SLU_IDX_DIVDEN   10'h283
`define SLU_RST_MODE     8'h00
`define SLU_RST_INTERP   8'h01
`define SLU_RST_PWR      8'h01
`define SLU_RST_LPD      8'hff
`define SLU_PWR_OFF_BIT  0
`define SLU_ST_LOCK_BIT  0
`define SLU_ST_CAL_BIT   1
`define SLU_CLK_NS       10
`define SLU_LOCK_NS      1000
`define SLU_CAL_NS       500
`define SLU_LOCK_CYC     ((`SLU_LOCK_NS + `SLU_CLK_NS - 1) / `SLU_CLK_NS)
`define SLU_CAL_CYC      ((`SLU_CAL_NS + `SLU_CLK_NS - 1) / `SLU_CLK_NS)
`define SLU_OCT_PER_WORD 4
`define SLU_QUEUE_OCT    12
`endif

// ### inc/slu_pkg.sv
// Types and mode decoding shared by both link ends
package slu_pkg;
  typedef struct packed {
    logic       ok;
    logic [3:0] lanes;
    logic [2:0] convs;
    logic [3:0] opf;
    logic       np12;
    logic       s8;
  } slu_mode_t;
  typedef struct packed {
    logic [2:0] conv;
    logic [2:0] smp;
  } slu_slot_t;
  typedef logic [5:0][7:0][15:0] slu_frame_t;
  typedef logic [7:0][39:0]      slu_lanes_t;
  typedef logic [11:0][7:0]      slu_octq_t;
  typedef struct packed {
    logic [7:0]            mode;
    logic [7:0]            interp;
    logic [7:0]            pwr;
    logic [7:0]            lpd;
    logic                  lock;
    logic                  cal;
    logic [7:0]            lock_cnt;
    logic [7:0]            cal_cnt;
    logic [7:0]            divnum;
    logic [7:0]            divden;
    logic [3:0]            cnt;
    slu_octq_t [7:0]       q;
    slu_frame_t            frame;
    logic                  frm_vld;
    logic [31:0]           prdata;
  } slu_rx_state_t;
  typedef struct packed {
    logic [3:0]            cnt;
    slu_octq_t [7:0]       q;
    slu_lanes_t            word;
    logic                  vld;
  } slu_tx_state_t;

  // Link mode code to lane count, converters, octets per frame, packing
  function automatic slu_mode_t slu_mode_info(input logic [7:0] mode);
    slu_mode_t r;
    r = '0;
    case (mode)
      8'h00: r = '{1'b1, 4'h1, 3'h2, 4'h4, 1'b0, 1'b0};
      8'h01: r = '{1'b1, 4'h2, 3'h4, 4'h4, 1'b0, 1'b0};
      8'h02: r = '{1'b1, 4'h3, 3'h6, 4'h4, 1'b0, 1'b0};
      8'h05: r = '{1'b1, 4'h1, 3'h2, 4'h3, 1'b1, 1'b0};
      8'h06: r = '{1'b1, 4'h2, 3'h4, 4'h3, 1'b1, 1'b0};
      8'h07: r = '{1'b1, 4'h1, 3'h4, 4'h8, 1'b0, 1'b0};
      8'h11: r = '{1'b1, 4'h8, 3'h2, 4'h3, 1'b1, 1'b1};
      default: r = '0;
    endcase
    return r;
  endfunction

  // Sample slots carried by one lane in one frame
  function automatic int slu_slots(input slu_mode_t mi);
    return (!mi.np12 && mi.opf == 4'h8) ? 4 : 2;
  endfunction

  // Converter and sample index of slot k on a lane
  function automatic slu_slot_t slu_slot_map(input slu_mode_t mi, input logic [2:0] lane,
                                             input logic [1:0] k);
    slu_slot_t r;
    r = '0;
    if (mi.s8) begin
      r.conv = {2'h0, lane[2]};
      r.smp  = {lane[1:0], k[0]};
    end else if (!mi.np12 && mi.opf == 4'h8) begin
      r.conv = {1'b0, k};
    end else begin
      r.conv = {lane[1:0], k[0]};
    end
    return r;
  endfunction
endpackage

// ### inc/slu_link_if.sv
// Parallel lane link between transmitter end and receiver end
`timescale 1ns/100ps
interface slu_link_if;
  slu_pkg::slu_lanes_t word;
  logic                vld;
  modport tx (output word, output vld);
  modport rx (input word, input vld);
endinterface

// ### rtl/slu_lane_tx.sv
// Transmitter end: sample packing into lane octets and quad-byte words
`timescale 1ns/100ps
`include "slu_regs.svh"
module slu_lane_tx (
  input  wire logic                clk_sys_i,
  input  wire logic                rstn_i,
  slu_link_if.tx                   link,
  input  wire logic [7:0]          mode_i,
  input  wire logic                res11_i,
  input  wire slu_pkg::slu_frame_t smp_i,
  input  wire logic                frm_vld_i,
  output logic                     frm_rdy_o
);
  slu_pkg::slu_tx_state_t s_reg;
  slu_pkg::slu_tx_state_t s_next;
  slu_pkg::slu_mode_t     mi;
  slu_pkg::slu_slot_t     sl;
  logic [3:0]             c;
  logic [15:0]            v;
  logic [3:0][11:0]       v12;
  logic [7:0][7:0]        fo;

  always_comb begin
    mi = slu_pkg::slu_mode_info(mode_i);
    s_next = s_reg;
    s_next.vld = 1'b0;
    c = s_reg.cnt;
    v = 16'h0000;
    v12 = '0;
    fo = '0;
    sl = '0;
    // Four octets per word, one per 10-bit group
    if (c >= 4'(`SLU_OCT_PER_WORD)) begin // RULE16
      s_next.vld = 1'b1;
      for (int l = 0; l < 8; l++) begin
        for (int j = 0; j < 4; j++) begin
          s_next.word[l][39 - 10 * j -: 10] = {2'b00, s_reg.q[l][j]}; // RULE15
        end
        for (int j = 0; j < 12; j++) begin
          s_next.q[l][j] = (j + 4 < 12) ? s_reg.q[l][j + 4] : 8'h00;
        end
      end
      c = c - 4'(`SLU_OCT_PER_WORD);
    end
    frm_rdy_o = mi.ok && ({1'b0, c} + {1'b0, mi.opf} <= 5'(`SLU_QUEUE_OCT));
    if (frm_vld_i && frm_rdy_o) begin // RULE14
      for (int l = 0; l < 8; l++) begin
        fo = '0;
        v12 = '0;
        for (int k = 0; k < 4; k++) begin
          sl = slu_pkg::slu_slot_map(mi, 3'(l), 2'(k));
          v = smp_i[sl.conv][sl.smp];
          if (l < int'(mi.lanes) && k < slu_pkg::slu_slots(mi)) begin
            if (mi.np12) begin
              v12[k] = {v[15:5], (res11_i || mi.s8) ? 1'b0 : v[4]}; // RULE4
            end else begin
              if (res11_i) begin
                v[4:0] = 5'h00; // RULE5
              end
              fo[2 * k]     = v[15:8]; // RULE6 RULE7 RULE8 RULE9
              fo[2 * k + 1] = v[7:0];
            end
          end
        end
        if (mi.np12) begin // RULE1 RULE2 RULE3
          fo[0] = v12[0][11:4];
          fo[1] = {v12[0][3:0], v12[1][11:8]};
          fo[2] = v12[1][7:0];
        end
        for (int j = 0; j < 8; j++) begin
          if (j < int'(mi.opf)) begin
            s_next.q[l][int'(c) + j] = fo[j];
          end
        end
      end
      c = c + mi.opf;
    end
    if (!mi.ok) begin
      c = 4'h0;
    end
    s_next.cnt = c;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign link.word = s_reg.word;
  assign link.vld  = s_reg.vld;
endmodule

// ### rtl/slu_lane_rx.sv
// Receive end: link control registers, lane reassembly and sample unpacking
`timescale 1ns/100ps
`include "slu_regs.svh"
// Operation
// RULE1: Mode 5: six nibbles, converters 0,1
// RULE2: Mode 6: lane0 converters 0,1; lane1 2,3
// RULE3: Mode 17: lanes 0-3 converter 0, 4-7 converter 1
// RULE4: Transmitter zeroes bit 0 for 11-bit 12-bit packing
// RULE5: Transmitter zeroes bits 4:0 for 11-bit 16-bit packing
// RULE6: Mode 0: upper then lower byte, two converters
// RULE7: Mode 1: two lanes, two converters each
// RULE8: Mode 2: lane k carries converters 2k, 2k+1
// RULE9: Mode 7: one lane, converters 0-3, eight octets
// RULE10: Eight identical lanes, 40-bit parallel words
// RULE11: Interface powered only while power bit 0 clear
// RULE12: Lane powered down while its bit is set
// RULE13: Termination calibration starts itself once configured
// RULE14: Lane rate from converters per lane and bits
// RULE15: Byte rate is lane rate over ten
// RULE16: Processing cycle decodes four bytes
// RULE17: Frame pops when F octets are present
// RULE18: Synth reference equals processing clock, lane rate/40
// RULE19: Synth dividers follow mode and interpolation
// RULE20: Status bit 0 reports synth lock
// RULE21: Samples delivered ascending, one frame per frame
module slu_lane_rx (
  input  wire logic                 clk_sys_i,
  input  wire logic                 rstn_i,
  slu_link_if.rx                    link,
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output logic      [31:0]          prdata_o,
  output logic                      pready_o,
  output logic                      pslverr_o,
  output slu_pkg::slu_frame_t       frm_smp_o,
  output logic                      frm_vld_o,
  output logic                      pll_lock_o,
  output logic      [7:0]           lane_pd_o
);
  slu_pkg::slu_rx_state_t s_reg;
  slu_pkg::slu_rx_state_t s_next;
  slu_pkg::slu_mode_t     mi;
  slu_pkg::slu_slot_t     sl;
  logic [9:0]             idx;
  logic                   hit;
  logic [31:0]            rd;
  logic [3:0]             c;
  logic [7:0]             dnum;
  logic [7:0]             dden;
  logic [15:0]            val;
  logic                   pll_on;
  logic                   cfg;

  always_comb begin
    mi = slu_pkg::slu_mode_info(s_reg.mode);
    s_next = s_reg;
    s_next.frm_vld = 1'b0;
    idx = paddr_i[11:2];
    hit = 1'b1;
    rd = 32'h0000_0000;
    sl = '0;
    val = 16'h0000;
    c = s_reg.cnt;

    // Register decode
    case (idx)
      `SLU_IDX_MODE: begin
        rd = {24'h00_0000, s_reg.mode};
      end
      `SLU_IDX_INTERP: begin
        rd = {24'h00_0000, s_reg.interp};
      end
      `SLU_IDX_PWR: begin
        rd = {24'h00_0000, s_reg.pwr};
      end
      `SLU_IDX_LPD: begin
        rd = {24'h00_0000, s_reg.lpd};
      end
      `SLU_IDX_PLLST: begin
        rd = 32'h0000_0000;
        rd[`SLU_ST_LOCK_BIT] = s_reg.lock; // RULE20
        rd[`SLU_ST_CAL_BIT]  = s_reg.cal;
      end
      `SLU_IDX_DIVNUM: begin
        rd = {24'h00_0000, s_reg.divnum};
      end
      `SLU_IDX_DIVDEN: begin
        rd = {24'h00_0000, s_reg.divden};
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (psel_i && !penable_i) begin
      s_next.prdata = rd;
    end
    if (psel_i && penable_i && pwrite_i && hit) begin
      case (idx)
        `SLU_IDX_MODE: begin
          s_next.mode = pwdata_i[7:0];
        end
        `SLU_IDX_INTERP: begin
          s_next.interp = pwdata_i[7:0];
        end
        `SLU_IDX_PWR: begin
          s_next.pwr = pwdata_i[7:0];
        end
        `SLU_IDX_LPD: begin
          s_next.lpd = pwdata_i[7:0];
        end
        default: begin
          s_next.mode = s_reg.mode;
        end
      endcase
    end

    // Synth divider ratio: reference over DAC clock/4 = M*NP / (8*L*interp)
    if (mi.ok) begin // RULE14 RULE18
      dnum = 8'(({5'h00, mi.convs} * (mi.np12 ? 8'h0c : 8'h10)) / {4'h0, mi.lanes});
    end else begin
      dnum = 8'h00;
    end
    dden = {s_reg.interp[4:0], 3'h0};
    pll_on = !s_reg.pwr[`SLU_PWR_OFF_BIT] && mi.ok && (s_reg.interp != 8'h00); // RULE11
    cfg = !s_reg.pwr[`SLU_PWR_OFF_BIT] && mi.ok;

    // Synth tuning and lock
    if (!pll_on) begin
      s_next.lock = 1'b0;
      s_next.lock_cnt = 8'h00;
    end else if (dnum != s_reg.divnum || dden != s_reg.divden) begin // RULE19
      s_next.divnum = dnum;
      s_next.divden = dden;
      s_next.lock = 1'b0;
      s_next.lock_cnt = 8'h00;
    end else if (!s_reg.lock) begin
      s_next.lock_cnt = s_reg.lock_cnt + 8'h01;
      if (s_reg.lock_cnt == 8'(`SLU_LOCK_CYC - 1)) begin
        s_next.lock = 1'b1; // RULE20
      end
    end

    // Termination calibration
    if (!cfg) begin
      s_next.cal = 1'b0;
      s_next.cal_cnt = 8'h00;
    end else if (!s_reg.cal) begin // RULE13
      s_next.cal_cnt = s_reg.cal_cnt + 8'h01;
      if (s_reg.cal_cnt == 8'(`SLU_CAL_CYC - 1)) begin
        s_next.cal = 1'b1;
      end
    end

    // Lane datapath
    if (!(s_reg.lock && s_reg.cal)) begin // RULE11
      c = 4'h0;
    end else begin
      if (mi.ok && c >= mi.opf) begin // RULE17
        s_next.frame = '0;
        s_next.frm_vld = 1'b1; // RULE21
        for (int l = 0; l < 8; l++) begin
          for (int k = 0; k < 4; k++) begin
            sl = slu_pkg::slu_slot_map(mi, 3'(l), 2'(k));
            if (l < int'(mi.lanes) && k < slu_pkg::slu_slots(mi)) begin
              if (mi.np12) begin // RULE1 RULE2 RULE3
                if (k == 0) begin
                  val = {s_reg.q[l][0], s_reg.q[l][1][7:4], 4'h0};
                end else begin
                  val = {s_reg.q[l][1][3:0], s_reg.q[l][2], 4'h0};
                end
              end else begin // RULE6 RULE7 RULE8 RULE9
                val = {s_reg.q[l][2 * k], s_reg.q[l][2 * k + 1]};
              end
              s_next.frame[sl.conv][sl.smp] = val; // RULE21
            end
          end
          for (int j = 0; j < 12; j++) begin
            if (j + int'(mi.opf) < 12) begin
              s_next.q[l][j] = s_reg.q[l][j + int'(mi.opf)];
            end else begin
              s_next.q[l][j] = 8'h00;
            end
          end
        end
        c = c - mi.opf;
      end
      if (link.vld) begin // RULE10 RULE16
        for (int l = 0; l < 8; l++) begin
          for (int j = 0; j < 4; j++) begin
            if (int'(c) + j < 12) begin
              // One 10-bit group per octet
              s_next.q[l][int'(c) + j] = s_reg.lpd[l] ? 8'h00
                                        : link.word[l][37 - 10 * j -: 8]; // RULE15 RULE12
            end
          end
        end
        c = c + 4'(`SLU_OCT_PER_WORD);
      end
    end
    s_next.cnt = c;
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_reg        <= '0;
      s_reg.mode   <= `SLU_RST_MODE;
      s_reg.interp <= `SLU_RST_INTERP;
      s_reg.pwr    <= `SLU_RST_PWR;
      s_reg.lpd    <= `SLU_RST_LPD;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata_o   = s_reg.prdata;
  assign pready_o   = 1'b1;
  assign pslverr_o  = psel_i && penable_i && !hit;
  assign frm_smp_o  = s_reg.frame;
  assign frm_vld_o  = s_reg.frm_vld;
  assign pll_lock_o = s_reg.lock;
  assign lane_pd_o  = s_reg.lpd | {8{s_reg.pwr[`SLU_PWR_OFF_BIT]}}; // RULE12
endmodule

// ### dv/slu_link_props.sv
// Checker for the lane link between the two ends
`timescale 1ns/100ps
module slu_link_props (
  input wire logic                clk_sys_i,
  input wire logic                rstn_i,
  input wire slu_pkg::slu_lanes_t word,
  input wire logic                vld,
  input wire logic [7:0]          mode_i,
  input wire logic                res11_i,
  input wire logic                frm_vld_i,
  input wire logic                frm_rdy_o
);
  localparam logic [39:0] PAD = 40'hc0300c0300;
  logic       m16;
  logic       mok;
  logic [7:0] pad_hit;
  logic [2:0] idle_reg;
  assign m16 = mode_i inside {8'h00, 8'h01, 8'h02, 8'h07};
  assign mok = m16 || (mode_i inside {8'h05, 8'h06, 8'h11});
  always_comb begin
    for (int i = 0; i < 8; i++) pad_hit[i] = |(word[i] & PAD);
  end
  // Cycles since the last frame was taken
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) idle_reg <= 3'h7;
    else if (frm_vld_i && frm_rdy_o) idle_reg <= 3'h0;
    else if (idle_reg != 3'h7) idle_reg <= idle_reg + 3'h1;
  end
  default clocking dc @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  a_group_pad: assert property (vld |-> pad_hit == 8'h00)
    else $error("pad bits set in lane word");
  a_rst_quiet: assert property ($rose(rstn_i) |-> !vld)
    else $error("word valid right after reset");
  a_res_lane0: assert property (vld && res11_i && m16 |->
    word[0][24:20] == 5'h00 && word[0][4:0] == 5'h00) else $error("lane 0 low bits not forced");
  a_res_lane1: assert property (vld && res11_i && mode_i inside {8'h01, 8'h02} |->
    word[1][24:20] == 5'h00 && word[1][4:0] == 5'h00) else $error("lane 1 low bits not forced");
  a_take_word: assert property (frm_vld_i && frm_rdy_o && m16 |-> ##2 vld)
    else $error("no word two cycles after frame take");
  a_bad_mode: assert property (!mok |-> !frm_rdy_o)
    else $error("ready in unknown mode");
  a_no_spurious: assert property (vld |-> idle_reg < 3'h5)
    else $error("word without a recent frame");
  a_vld_mode_ok: assert property (vld |-> $past(mok))
    else $error("word sent under unknown mode");
endmodule

// ### dv/test_serial_lane_sample_unpacker.sv
// Bench joining both link ends, register and frame checks
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); bad_count++; end end
module test_serial_lane_sample_unpacker;
  localparam logic [7:0] TMODE [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h06, 8'h07, 8'h11, 8'h01, 8'h05};
  localparam int         TL    [9] = '{1, 2, 3, 1, 2, 1, 8, 2, 1};
  localparam int         TM    [9] = '{2, 4, 6, 2, 4, 4, 2, 4, 2};
  localparam int         TS    [9] = '{1, 1, 1, 1, 1, 1, 8, 1, 1};
  localparam bit         T12   [9] = '{0, 0, 0, 1, 1, 0, 1, 0, 1};
  localparam bit         TR    [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  logic                clk_sys_i;
  logic                rstn_i;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [11:0]         paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  slu_pkg::slu_frame_t frm_smp;
  logic                frm_vld_o;
  logic                pll_lock;
  logic [7:0]          lane_pd;
  logic [7:0]          mode_i;
  logic                res11_i;
  slu_pkg::slu_frame_t smp;
  logic                frm_vld_i;
  logic                frm_rdy_o;
  logic [31:0]         rd_data;
  logic                rd_err;
  int                  bad_count;
  int                  n_checks;
  int                  cyc;
  slu_pkg::slu_frame_t rxq[$];
  slu_link_if slu_link_if_inst ();
  slu_lane_tx slu_lane_tx_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(slu_link_if_inst),
    .mode_i(mode_i), .res11_i(res11_i), .smp_i(smp), .frm_vld_i(frm_vld_i),
    .frm_rdy_o(frm_rdy_o));
  slu_lane_rx slu_lane_rx_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .link(slu_link_if_inst),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .frm_smp_o(frm_smp),
    .frm_vld_o(frm_vld_o), .pll_lock_o(pll_lock), .lane_pd_o(lane_pd));
  slu_link_props slu_link_props_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .word(slu_link_if_inst.word), .vld(slu_link_if_inst.vld), .mode_i(mode_i),
    .res11_i(res11_i), .frm_vld_i(frm_vld_i), .frm_rdy_o(frm_rdy_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // Frame n: converter, sample and frame number in the nibbles
  function automatic slu_pkg::slu_frame_t gen(input int n);
    gen = '0;
    for (int c = 0; c < 6; c++)
      for (int s = 0; s < 8; s++) gen[c][s] = 16'(c * 4096 + s * 256 + n * 16 + 15);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do @(posedge clk_sys_i); while (pready !== 1'b1);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge clk_sys_i);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0);
    `CHK($sformatf("reg %0h", idx), e, rd_data)
  endtask
  task automatic send(input int n);
    @(posedge clk_sys_i);
    smp <= gen(n);
    frm_vld_i <= 1'b1;
    do @(negedge clk_sys_i); while (frm_rdy_o !== 1'b1);
  endtask
  always @(negedge clk_sys_i) if (frm_vld_o === 1'b1) rxq.push_back(frm_smp);
  // One mode: configure, wait for lock, send four frames, compare
  task automatic run(input int r);
    logic [15:0]         mk;
    logic [15:0]         e;
    slu_pkg::slu_frame_t ex;
    mk = !T12[r] ? (TR[r] ? 16'hffe0 : 16'hffff) : ((TR[r] || TS[r] == 8) ? 16'hffe0 : 16'hfff0);
    @(posedge clk_sys_i);
    mode_i <= TMODE[r];
    res11_i <= TR[r];
    apb(1'b1, 10'h110, {24'h0, TMODE[r]});
    apb(1'b1, 10'h201, {24'h0, ~8'((1 << TL[r]) - 1)});
    repeat (2) @(negedge clk_sys_i);
    `CHK("lane_pd", ~8'((1 << TL[r]) - 1), lane_pd)
    rd_data = 32'h0;
    for (int i = 0; i < 200 && rd_data[1:0] !== 2'b11; i++) apb(1'b0, 10'h281, 32'h0);
    `CHK("status", 32'h3, rd_data)
    rd(10'h282, 32'((TM[r] * (T12[r] ? 12 : 16)) / TL[r]));
    rd(10'h283, 32'h10);
    rxq.delete();
    for (int n = 0; n < 4; n++) send(n);
    @(posedge clk_sys_i);
    frm_vld_i <= 1'b0;
    for (int i = 0; i < 60 && rxq.size() < 4; i++) @(negedge clk_sys_i);
    `CHK("frames", 4, rxq.size())
    for (int n = 0; n < rxq.size() && n < 4; n++) begin
      ex = gen(n);
      for (int c = 0; c < 6; c++)
        for (int s = 0; s < 8; s++) begin
          e = (c < TM[r] && s < TS[r]) ? (ex[c][s] & mk) : 16'h0;
          `CHK($sformatf("m%0h f%0d c%0d s%0d", TMODE[r], n, c, s), e, rxq[n][c][s])
        end
    end
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      print_verdict();
    end
  end
  initial begin
    rstn_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    mode_i = 8'h03;
    res11_i = 1'b0;
    smp = '0;
    frm_vld_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    @(negedge clk_sys_i);
    `CHK("lane_pd rst", 8'hff, lane_pd)
    rd(10'h110, 32'h00);
    rd(10'h111, 32'h01);
    rd(10'h200, 32'h01);
    rd(10'h201, 32'hff);
    rd(10'h281, 32'h00);
    rd(10'h3ff, 32'h00);
    `CHK("pslverr", 1'b1, rd_err)
    repeat (150) @(negedge clk_sys_i);
    `CHK("lock off", 1'b0, pll_lock)
    apb(1'b1, 10'h111, 32'h2);
    apb(1'b1, 10'h200, 32'h0);
    for (int r = 0; r < 9; r++) run(r);
    apb(1'b1, 10'h200, 32'h1);
    repeat (2) @(negedge clk_sys_i);
    `CHK("lane_pd off", 8'hff, lane_pd)
    `CHK("lock drop", 1'b0, pll_lock)
    print_verdict();
  end
endmodule
